// ==== logic/tcc_timer.sv ====
// timer compare channel control: counter, compare channels, port takeover
// Overview of operation
// - 16-bit prescaled counter, eight 16-bit capture/compare channels; only compare is built here.
// - an enabled compare on a pin overrides that pin's direction bit.
// - port data writes latch while timer owns pin; driven once released.
// - channel select bit 0 means input capture, 1 means output compare; the code has no capture, a 0 channel never matches.
// - force register always reads as zero.
// - force bit runs the compare action now without setting the flag.
// - compare channel with ch7 mask set is an output; direction bit unchanged.
// - channel-7 match copies masked ch7 data bits to the port.
// - ch7 data overrides a channel's own action on a same-cycle match.
// - counter writes ignored in normal mode; reads always allowed.
// - first count after a counter write may be short; no resync.
// - clear-on-ch7 bit makes a channel-7 match reset the counter.
// - action pair: 00 off, 01 toggle, 10 clear, 11 set.
// - prescale codes 000..101 divide by 1..32; 110, 111 reserved.
// - timer-on bit 0 stops the timer and counter.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int NCH = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              special_mode,
  input  wire logic [TCC_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [TCC_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NCH-1:0]    pin_in,
  output logic [NCH-1:0]         pin_out,
  output logic [NCH-1:0]         pin_oe,
  output logic                   irq
);
  // software state
  logic [NCH-1:0] func_q, func_d, mask_q, mask_d, pdat_q, pdat_d;
  logic [NCH-1:0] dir_q, dir_d, port_q, port_d;
  logic [7:0]     ctrl_q, ctrl_d;
  logic [15:0]    mode_q, mode_d;
  logic [15:0]    cnt_q, cnt_d;
  logic [15:0]    cmp_q [NCH];
  logic [15:0]    cmp_d [NCH];
  logic [IRQ_W-1:0] stat_q, stat_d, imsk_q, imsk_d;
  logic [NCH-1:0] oc_q, oc_d;
  // bus handshake state
  logic           aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [TCC_AW-1:0] awa_q, awa_d;
  logic [31:0]    wd_q, wd_d, rd_q, rd_d;
  logic [1:0]     br_q, br_d, rr_q, rr_d;
  // internal
  logic           tick, wr_go, rd_go, wr_ok, rd_ok;
  logic [NCH-1:0] match, forced, fire;
  logic [7:0]     wb;
  logic [31:0]    rv;

  tcc_prescaler u_pre (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (ctrl_q[CTRL_TIMER_ON]),
    .code  (ctrl_q[CTRL_PRE_LSB +: PRE_W]),
    .tick  (tick)
  );

  // a write runs once both address and data have arrived, in any order
  assign wr_go = aw_q && w_q && !bv_q;
  assign rd_go = s_axi_arvalid && !rv_q;
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign wb            = wd_q[7:0];

  // compare matches only count in compare channels while the timer runs
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign match[g]  = func_q[g] && ctrl_q[CTRL_TIMER_ON]
                         && tick && (cnt_q == cmp_q[g]);
      assign forced[g] = wr_go && (awa_q == ADR_FORCE)
                         && wd_q[g] && s_axi_wstrb[0];
      assign fire[g]   = match[g] || forced[g];
      // pin ownership: action mode or ch7 mask takes it from the port
      assign pin_oe[g] = (func_q[g] && (mode_q[2*g +: 2] != 2'h0
                         || mask_q[g])) ? 1'b1 : dir_q[g];
      assign pin_out[g] = (func_q[g] && (mode_q[2*g +: 2] != 2'h0
                          || mask_q[g])) ? oc_q[g] : port_q[g];
    end
  endgenerate

  assign irq = |(stat_q & imsk_q);

  // read mux; force register always reads zero
  always_comb begin
    rv    = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr >= ADR_CMP_BASE
        && s_axi_araddr < ADR_CMP_BASE + 8'(4 * NCH)
        && s_axi_araddr[1:0] == 2'h0) begin
      rv = {16'h0000, cmp_q[3'((s_axi_araddr - ADR_CMP_BASE) >> 2)]};
    end else begin
      unique case (s_axi_araddr)
        ADR_FUNC_SEL:  rv[NCH-1:0] = func_q;
        ADR_FORCE:     rv = 32'h00000000;
        ADR_PIN_MASK:  rv[NCH-1:0] = mask_q;
        ADR_PIN_DATA:  rv[NCH-1:0] = pdat_q;
        ADR_COUNT:     rv[15:0] = cnt_q;
        ADR_CTRL:      rv[7:0] = ctrl_q;
        ADR_ACT_MODE:  rv[15:0] = mode_q;
        ADR_PORT_DIR:  rv[NCH-1:0] = dir_q;
        ADR_PORT_DATA: rv[NCH-1:0] = (pin_oe & port_q) | (~pin_oe & pin_in);
        ADR_IRQ_STAT:  rv[IRQ_W-1:0] = stat_q;
        ADR_IRQ_MASK:  rv[IRQ_W-1:0] = imsk_q;
        default:       rd_ok = 1'b0;
      endcase
    end
  end

  // write decode of the compare array
  always_comb begin
    wr_ok = 1'b1;
    for (int ci = 0; ci < NCH; ci++) begin
      cmp_d[ci] = cmp_q[ci];
      if (wr_go && awa_q == ADR_CMP_BASE + 8'(4 * ci)) begin
        cmp_d[ci] = wd_q[15:0];
      end
    end
    if (!(awa_q inside {ADR_FUNC_SEL, ADR_FORCE, ADR_PIN_MASK, ADR_PIN_DATA,
        ADR_COUNT, ADR_CTRL, ADR_ACT_MODE, ADR_PORT_DIR, ADR_PORT_DATA,
        ADR_IRQ_STAT, ADR_IRQ_MASK})
        && !(awa_q >= ADR_CMP_BASE && awa_q < ADR_CMP_BASE + 8'(4 * NCH)
        && awa_q[1:0] == 2'h0)) begin
      wr_ok = 1'b0;
    end
  end

  // register, counter, compare action and bus next-state logic
  always_comb begin
    func_d = func_q;  mask_d = mask_q;  pdat_d = pdat_q;
    dir_d  = dir_q;   port_d = port_q;  ctrl_d = ctrl_q;
    mode_d = mode_q;  cnt_d  = cnt_q;   imsk_d = imsk_q;
    oc_d   = oc_q;    stat_d = stat_q;
    aw_d = aw_q;  w_d = w_q;  bv_d = bv_q;  rv_d = rv_q;
    awa_d = awa_q;  wd_d = wd_q;  rd_d = rd_q;  br_d = br_q;  rr_d = rr_q;
    // bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (rd_go) begin
      rv_d = 1'b1;
      rd_d = rv;
      rr_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    // register writes (low byte lane; counter, compare and action mode need all 16 bits, irq registers 9)
    if (wr_go) begin
      unique case (awa_q)
        ADR_FUNC_SEL:  func_d = wb;
        ADR_PIN_MASK:  mask_d = wb;
        ADR_PIN_DATA:  pdat_d = wb;
        ADR_CTRL:      ctrl_d = wb;
        ADR_ACT_MODE:  mode_d = wd_q[15:0];
        ADR_PORT_DIR:  dir_d  = wb;
        ADR_PORT_DATA: port_d = wb;
        ADR_IRQ_MASK:  imsk_d = wd_q[IRQ_W-1:0];
        ADR_IRQ_STAT:  stat_d = stat_q & ~wd_q[IRQ_W-1:0];
        default: ;
      endcase
    end
    // counter: count, clear on ch7, special-mode write
    if (ctrl_q[CTRL_TIMER_ON] && tick) begin
      if (match[NCH-1] && ctrl_q[CTRL_CLR_ON_CH7]) begin
        cnt_d = RST_WORD;
      end else begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'hFFFF) stat_d[IRQ_OVF] = 1'b1;
      end
    end
    if (wr_go && awa_q == ADR_COUNT && special_mode) begin
      cnt_d = wd_q[15:0];
    end
    // per-channel action, then ch7 data overrides masked bits
    for (int ci = 0; ci < NCH; ci++) begin
      if (fire[ci]) begin
        unique case (mode_q[2*ci +: 2])
          2'h0: oc_d[ci] = oc_q[ci];
          2'h1: oc_d[ci] = ~oc_q[ci];
          2'h2: oc_d[ci] = 1'b0;
          2'h3: oc_d[ci] = 1'b1;
        endcase
      end
      if (fire[NCH-1] && mask_q[ci]) begin
        oc_d[ci] = pdat_q[ci];
      end
      if (match[ci]) stat_d[ci] = 1'b1;                    // set wins
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      func_q <= RST_BYTE;  mask_q <= RST_BYTE;  pdat_q <= RST_BYTE;
      dir_q  <= RST_BYTE;  port_q <= RST_BYTE;  ctrl_q <= RST_BYTE;
      mode_q <= RST_WORD;  cnt_q  <= RST_WORD;  oc_q   <= RST_BYTE;
      stat_q <= '0;  imsk_q <= '0;
      aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;
      awa_q <= '0;  wd_q <= '0;  rd_q <= '0;
      br_q <= RESP_OKAY;  rr_q <= RESP_OKAY;
      for (int k = 0; k < NCH; k++) cmp_q[k] <= RST_WORD;
    end else begin
      func_q <= func_d;  mask_q <= mask_d;  pdat_q <= pdat_d;
      dir_q  <= dir_d;   port_q <= port_d;  ctrl_q <= ctrl_d;
      mode_q <= mode_d;  cnt_q  <= cnt_d;   oc_q   <= oc_d;
      stat_q <= stat_d;  imsk_q <= imsk_d;
      aw_q <= aw_d;  w_q <= w_d;  bv_q <= bv_d;  rv_q <= rv_d;
      awa_q <= awa_d;  wd_q <= wd_d;  rd_q <= rd_d;
      br_q <= br_d;  rr_q <= rr_d;
      for (int k = 0; k < NCH; k++) cmp_q[k] <= cmp_d[k];
    end
  end
endmodule
`default_nettype wire

// ==== logic/tcc_pkg.sv ====
// package for the timer compare channel control block: offsets, fields, resets
package tcc_pkg;
  localparam int          TCC_AW           = 8;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0]  ADR_FUNC_SEL     = 8'h00;
  localparam logic [7:0]  ADR_FORCE        = 8'h04;
  localparam logic [7:0]  ADR_PIN_MASK     = 8'h08;
  localparam logic [7:0]  ADR_PIN_DATA     = 8'h0C;
  localparam logic [7:0]  ADR_COUNT        = 8'h10;
  localparam logic [7:0]  ADR_CTRL         = 8'h14;
  localparam logic [7:0]  ADR_ACT_MODE     = 8'h18;
  localparam logic [7:0]  ADR_PORT_DIR     = 8'h1C;
  localparam logic [7:0]  ADR_PORT_DATA    = 8'h20;
  localparam logic [7:0]  ADR_IRQ_STAT     = 8'h24;
  localparam logic [7:0]  ADR_IRQ_MASK     = 8'h28;
  localparam logic [7:0]  ADR_CMP_BASE     = 8'h40; // 8 words 0x40..0x5C
  // control register fields
  localparam int          CTRL_TIMER_ON    = 7;
  localparam int          CTRL_CLR_ON_CH7  = 3;
  localparam int          CTRL_PRE_LSB     = 0;
  localparam int          PRE_W            = 3;
  localparam logic [2:0]  PRE_MAX_CODE     = 3'h5;
  // reset values
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_WORD         = 16'h0000;
  // status bits: 0..7 channel compare matches, 8 counter overflow
  localparam int          IRQ_W            = 9;
  localparam int          IRQ_OVF          = 8;
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// ==== logic/tcc_prescaler.sv ====
// prescaler producing a one-cycle count enable at clk / 2^code, and at clk / 32 for codes 6 and 7
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler
  import tcc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             run,
  input  wire logic [PRE_W-1:0] code,
  output logic                  tick
);
  logic [4:0] div_q;
  logic [4:0] div_d;
  logic [4:0] lim;

  // divider wraps at 2^code-1, at most 31; a code change acts at once on the running count
  always_comb begin
    lim   = 5'((6'h01 << code) - 6'h01);
    div_d = div_q;
    tick  = 1'b0;
    if (run) begin
      if (div_q >= lim) begin
        div_d = 5'h00;
        tick  = 1'b1;
      end else begin
        div_d = div_q + 5'h01;
      end
    end
  end

  // no resync on counter writes: the first period after one may be short
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_d;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tcc_sva.sv ====
// checker of bus handshakes and read values of the timer block
`timescale 1ns/1ps
`default_nettype none
module tcc_sva
  import tcc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [TCC_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a write taken whole in one cycle, and a read taken
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (
    wr_take_s |-> ##2 s_axi_bvalid) else $error("write answer late");
  write_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  read_answer_a: assert property (
    rd_take_s |=> s_axi_rvalid) else $error("read answer late");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  read_busy_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  force_zero_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADR_FORCE
    |=> s_axi_rdata == 32'h0) else $error("force register not zero");
  bad_addr_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hFC
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read accepted");
endmodule
bind tcc_timer tcc_sva i_tcc_sva (.clk, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ==== tb/tcc_pins.sv ====
// model of the outside world at the timer port pins
`timescale 1ns/1ps
`default_nettype none
module tcc_pins #(
  parameter int NCH = 8
) (
  input  wire logic [NCH-1:0] pin_out,
  input  wire logic [NCH-1:0] pin_oe,
  input  wire logic [NCH-1:0] ext_lvl,
  output logic      [NCH-1:0] pin_in
);
  // a driven pin reads back its own level; a free pin shows the outside
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the timer compare channel control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tcc_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, special_mode = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, ext = 8'h00, p;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic        aw = 1'b0, wv = 1'b0, br = 1'b0, ar = 1'b0, rr = 1'b0;
  logic        awr, wrdy, bv, arr, rv, irq, e = 1'b0;
  logic [1:0]  bresp, rresp, rs, k;
  logic [7:0]  pin_out, pin_oe, pin_in;
  logic [15:0] v;
  int          num_errors = 0, n_compared = 0, cyc = 0;
  always #10 clk = ~clk;
  tcc_timer i_tcc_timer (.clk, .rst_b, .special_mode, .s_axi_awaddr(awa),
    .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .pin_in, .pin_out, .pin_oe, .irq);
  tcc_pins i_tcc_pins (.pin_out, .pin_oe, .ext_lvl(ext), .pin_in);
  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; aw <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) aw <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    rs = bresp;
    br <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    ara <= a; ar <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) ar <= 1'b0;
    end while (!rv);
    rd = rdat; rs = rresp;
    rr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    rdr(a);
    chk(nm, x, rd);
  endtask
  // pin level after one compare action of the given code
  function automatic logic act(input logic [1:0] c, input logic o);
    case (c)
      2'h1: act = ~o;
      2'h2: act = 1'b0;
      2'h3: act = 1'b1;
      default: act = o;
    endcase
  endfunction
  // guard against a hung handshake
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h5A84));
    ext = 8'($urandom);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("oe_reset", 32'h0, pin_oe);
    rchk("func_sel", ADR_FUNC_SEL, 32'h0);
    rdr(8'hFC);
    chk("bad_rresp", RESP_SLVERR, rs);
    wr(8'hFC, 32'h1);
    chk("bad_bresp", RESP_SLVERR, rs);
    // channel 0 as compare: action codes 01, 10 and 11 (never 00), run by force
    wr(ADR_FUNC_SEL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      k = (i < 3) ? 2'(i + 1) : 2'($urandom_range(3, 1));
      wr(ADR_ACT_MODE, {30'h0, k});
      chk("oe_taken", 32'h1, pin_oe[0]);
      wr(ADR_FORCE, 32'h1);
      e = act(k, e);
      chk("forced_pin", e, pin_out[0]);
    end
    rchk("force_rd", ADR_FORCE, 32'h0);
    rchk("no_flag", ADR_IRQ_STAT, 32'h0);
    // port data is only latched while the timer owns the pin
    p = 8'($urandom);
    wr(ADR_PORT_DATA, {24'h0, p});
    chk("pin_kept", e, pin_out[0]);
    wr(ADR_ACT_MODE, 32'h0);
    wr(ADR_PORT_DIR, 32'hFF);
    chk("pin_freed", p, pin_out);
    chk("oe_freed", 32'hFF, pin_oe);
    rchk("port_rd", ADR_PORT_DATA, {24'h0, p});
    // ch7 mask takes pin 1; ch7 data wins a same-cycle action
    wr(ADR_PORT_DIR, 32'h0);
    rchk("port_pins", ADR_PORT_DATA, {24'h0, ext});
    wr(ADR_FUNC_SEL, 32'h82);
    wr(ADR_PIN_MASK, 32'h2);
    chk("oe_mask", 32'h1, pin_oe[1]);
    rchk("dir_kept", ADR_PORT_DIR, 32'h0);
    wr(ADR_ACT_MODE, 32'hC);
    wr(ADR_FORCE, 32'h82);
    chk("ch7_wins", 32'h0, pin_out[1]);
    wr(ADR_PIN_DATA, 32'h2);
    wr(ADR_FORCE, 32'h80);
    chk("ch7_copy", 32'h1, pin_out[1]);
    // counter writes need special mode; a stopped timer holds them
    v = 16'($urandom);
    wr(ADR_COUNT, {16'h0, v});
    rchk("cnt_normal", ADR_COUNT, 32'h0);
    special_mode <= 1'b1;
    wr(ADR_COUNT, {16'h0, v});
    rchk("cnt_special", ADR_COUNT, {16'h0, v});
    wr(ADR_COUNT, 32'h0);
    special_mode <= 1'b0;
    // ch7 match at 0x28 clears the counter and sets flags
    wr(ADR_CMP_BASE + 8'h1C, 32'h28);
    wr(ADR_CTRL, 32'h88);
    repeat (30) begin
      rdr(ADR_COUNT);
      chk("cnt_bound", 32'h1, rd[15:0] <= 16'h0028);
    end
    rchk("flags", ADR_IRQ_STAT, 32'h82);
    chk("irq_masked", 32'h0, irq);
    wr(ADR_IRQ_MASK, 32'h80);
    chk("irq_on", 32'h1, irq);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_IRQ_STAT, 32'h80);
    chk("irq_off", 32'h0, irq);
    rchk("flag_left", ADR_IRQ_STAT, 32'h2);
    rdr(ADR_COUNT);
    v = rd[15:0];
    rchk("cnt_stop", ADR_COUNT, {16'h0, v});
    give_verdict();
  end
endmodule
`default_nettype wire
